// file: design/sms_modem_setup.sv
/*
 * SPI register port and parameter decode for the spread-spectrum modem:
 * mode register with range select, spread exponent, code ratio, bandwidth,
 * headerless select, spreading-factor-6 tuning registers and the data FIFO.
 * Assumes SPI mode 0 with a clock at most one eighth of ref_clk.
 */
// Functional notes
// - modem select changes only while in Sleep
// - modem select swaps the register map
// - modem FIFO reached through the SPI port
// - spread exponent 6 to 12, 2^SF chips
// - code ratio 1..4 gives 4/5 to 4/8
// - receiver adopts header-carried code ratio
// - bandwidth is total channel, 7.8 to 500 kHz
// - symbol rate is bandwidth over 2^SF
// - headerless select bit in symbol timeout high
`timescale 1ns/1ns
module sms_modem_setup
	import sms_pkg::*;
#(
	parameter int FIFO_AW = 8
) (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic               spiSck,
	input  wire logic               spiNss_n,
	input  wire logic               spiMosi,
	output logic                    spiMiso,
	output logic                    spiMisoOe,
	input  wire logic               hdrCrValid,
	input  wire logic [2:0]         hdrCr,
	input  wire logic [FIFO_AW-1:0] modemFifoAddr,
	input  wire logic               modemFifoWe,
	input  wire logic [7:0]         modemFifoWdata,
	output logic      [7:0]         modemFifoRdata,
	output logic                    longRangeSel,
	output logic      [2:0]         opMode,
	output logic      [3:0]         activeSpread,
	output logic      [2:0]         activeCodeRatio,
	output logic      [3:0]         activeBandwidth,
	output logic                    activeHeaderless,
	output logic      [12:0]        chipsPerSymbol,
	output logic      [3:0]         codeOverheadQuarters,
	output logic      [18:0]        symbolRateHz
);

	typedef struct packed {
		logic [2:0]  sckS, nssS, mosiS;
		logic        sckF, nssF, mosiF;
		logic [2:0]  bitCnt;
		logic        addrPhase;
		logic        isWrite;
		logic [6:0]  addr;
		logic [7:0]  rxSh, txSh;
		logic        longRange;
		logic [2:0]  mode;
		logic [3:0]  sf;
		logic [2:0]  cr;
		logic [3:0]  bw;
		logic        headerless;
		logic [7:0]  fifoPtr, tune31, thr37;
		logic [3:0]  actSf;
		logic [2:0]  actCr;
		logic [3:0]  actBw;
		logic        actHdrless;
		logic [12:0] chips;
		logic [3:0]  overhead;
		logic [18:0] symRate;
	} sms_state_type;

	sms_state_type st_r, st_nxt;
	logic                sckFNew, sckRise, sckFall, byteEnd;
	logic                wrEn, fifoAccess;
	logic [7:0]          rxByte, spiFifoRd, rdMux;
	logic [FIFO_AW-1:0]  spiFifoAddr;
	logic [6:0]          loadAddr;

	////////////////////////////////////////////////////////////////////////////
	// SPI edge detection on the filtered pins. Only stages 1 and 2 of each
	// chain are looked at; a level counts once both agree.
	assign sckFNew = (st_r.sckS[1] == st_r.sckS[2]) ? st_r.sckS[2] : st_r.sckF;
	assign sckRise = !st_r.nssF && !st_r.sckF && sckFNew;
	assign sckFall = !st_r.nssF && st_r.sckF && !sckFNew;
	assign byteEnd = sckRise && st_r.bitCnt == 3'h7;
	assign rxByte  = {st_r.rxSh[6:0], st_r.mosiF};
	assign wrEn    = byteEnd && !st_r.addrPhase && st_r.isWrite;
	assign fifoAccess = byteEnd && !st_r.addrPhase && st_r.longRange
		&& st_r.addr == ADDR_FIFO;
	// Writes land at the pointer; a read burst fetches one byte ahead.
	assign spiFifoAddr = (fifoAccess && !st_r.isWrite) ? FIFO_AW'(st_r.fifoPtr + 8'h01)
		: FIFO_AW'(st_r.fifoPtr);
	// The FIFO stays at one address in a burst; any other register steps on.
	assign loadAddr = st_r.addrPhase ? rxByte[6:0]
		: (st_r.addr == ADDR_FIFO ? st_r.addr : st_r.addr + 7'h01);

	sms_dual_buffer #(
		.AW (FIFO_AW),
		.DW (8)
	) u_buffer (
		.clk    (ref_clk),
		.aAddr  (spiFifoAddr),
		.aWe    (wrEn && fifoAccess),
		.aWdata (rxByte),
		.aRdata (spiFifoRd),
		.bAddr  (modemFifoAddr),
		.bWe    (modemFifoWe),
		.bWdata (modemFifoWdata),
		.bRdata (modemFifoRdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read decode. Outside the spread-spectrum map only the mode register
	// answers; the other modem's registers live elsewhere and read zero here.
	always_comb begin
		rdMux = 8'h00;
		if (loadAddr == ADDR_OPMODE) begin
			rdMux = {st_r.longRange, 4'h0, st_r.mode};
		end else if (st_r.longRange) begin
			unique case (loadAddr)
				ADDR_FIFO:         rdMux = spiFifoRd;
				ADDR_FIFO_PTR:     rdMux = st_r.fifoPtr;
				ADDR_TX_SETUP:     rdMux = {st_r.bw, st_r.cr, 1'b0};
				ADDR_MODEM_SETUP2: rdMux = {st_r.sf, 4'h0};
				ADDR_SYMTO_HI:     rdMux = {5'h00, st_r.headerless, 2'h0};
				ADDR_ACTIVE:       rdMux = {st_r.actSf, st_r.actCr, st_r.actHdrless};
				ADDR_SF6_TUNE:     rdMux = st_r.tune31;
				ADDR_SF6_THR:      rdMux = st_r.thr37;
				default:           rdMux = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		st_nxt = st_r;
		st_nxt.sckS  = {st_r.sckS[1:0], spiSck};
		st_nxt.nssS  = {st_r.nssS[1:0], spiNss_n};
		st_nxt.mosiS = {st_r.mosiS[1:0], spiMosi};
		st_nxt.sckF  = sckFNew;
		st_nxt.nssF  = (st_r.nssS[1] == st_r.nssS[2]) ? st_r.nssS[2] : st_r.nssF;
		st_nxt.mosiF = (st_r.mosiS[1] == st_r.mosiS[2]) ? st_r.mosiS[2] : st_r.mosiF;
		if (st_r.nssF) begin
			st_nxt.bitCnt    = 3'h0;
			st_nxt.addrPhase = 1'b1;
			st_nxt.txSh      = 8'h00;
		end else if (sckRise) begin
			st_nxt.bitCnt = st_r.bitCnt + 3'h1;
			st_nxt.rxSh   = rxByte;
		end else if (sckFall && st_r.bitCnt != 3'h0) begin
			st_nxt.txSh = {st_r.txSh[6:0], 1'b0};
		end
		if (byteEnd) begin
			st_nxt.addrPhase = 1'b0;
			st_nxt.addr      = loadAddr;
			if (st_r.addrPhase) begin
				st_nxt.isWrite = rxByte[7];
			end
			st_nxt.txSh = rdMux;
		end
		if (fifoAccess) begin
			st_nxt.fifoPtr = st_r.fifoPtr + 8'h01;
		end
		if (wrEn) begin
			if (st_r.addr == ADDR_OPMODE) begin
				st_nxt.mode = rxByte[2:0];
				if (st_r.mode == MODE_SLEEP) begin
					st_nxt.longRange = rxByte[OPM_RANGE_BIT];
				end
				// Parameters are sampled only on entry to a packet mode.
				if ((rxByte[2:0] == MODE_TX || rxByte[2:0] == MODE_RX)
					&& st_r.mode != rxByte[2:0]) begin
					st_nxt.actSf      = st_r.sf;
					st_nxt.actCr      = st_r.cr;
					st_nxt.actBw      = st_r.bw;
					st_nxt.actHdrless = st_r.headerless;
				end
			end else if (st_r.longRange) begin
				unique case (st_r.addr)
					ADDR_FIFO_PTR: st_nxt.fifoPtr = rxByte;
					ADDR_TX_SETUP: begin
						if (rxByte[7:BW_LSB] <= BW_MAX) begin
							st_nxt.bw = rxByte[7:BW_LSB];
						end
						if (rxByte[3:CR_LSB] >= CR_MIN && rxByte[3:CR_LSB] <= CR_MAX) begin
							st_nxt.cr = rxByte[3:CR_LSB];
						end
					end
					ADDR_MODEM_SETUP2: begin
						// Codes outside the legal span are dropped, not clamped.
						if (rxByte[7:SF_LSB] >= SF_MIN && rxByte[7:SF_LSB] <= SF_MAX) begin
							st_nxt.sf = rxByte[7:SF_LSB];
						end
					end
					ADDR_SYMTO_HI: st_nxt.headerless = rxByte[HDRLESS_BIT];
					ADDR_SF6_TUNE: st_nxt.tune31 = rxByte;
					ADDR_SF6_THR:  st_nxt.thr37 = rxByte;
					default: ;
				endcase
			end
		end
		if (hdrCrValid && !st_r.actHdrless && hdrCr >= CR_MIN && hdrCr <= CR_MAX) begin
			st_nxt.actCr = hdrCr;
		end
		st_nxt.chips    = 13'h0001 << st_nxt.actSf;
		st_nxt.overhead = 4'({1'b0, st_nxt.actCr} + 4'h4);
		st_nxt.symRate  = sms_bw_hz(st_nxt.actBw) >> st_nxt.actSf;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r            <= '0;
			st_r.nssS       <= 3'h7;
			st_r.nssF       <= 1'b1;
			st_r.addrPhase  <= 1'b1;
			st_r.mode       <= MODE_SLEEP;
			st_r.sf         <= SF_RST;
			st_r.cr         <= CR_RST;
			st_r.bw         <= BW_RST;
			st_r.fifoPtr    <= PTR_RST;
			st_r.tune31     <= TUNE_RST;
			st_r.thr37      <= THR_RST;
			st_r.actSf      <= SF_RST;
			st_r.actCr      <= CR_RST;
			st_r.actBw      <= BW_RST;
			st_r.chips      <= CHIPS_RST;
			st_r.overhead   <= OVH_RST;
			st_r.symRate    <= RATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign spiMiso              = st_r.txSh[7];
	assign spiMisoOe            = !st_r.nssF;
	assign longRangeSel         = st_r.longRange;
	assign opMode               = st_r.mode;
	assign activeSpread         = st_r.actSf;
	assign activeCodeRatio      = st_r.actCr;
	assign activeBandwidth      = st_r.actBw;
	assign activeHeaderless     = st_r.actHdrless;
	assign chipsPerSymbol       = st_r.chips;
	assign codeOverheadQuarters = st_r.overhead;
	assign symbolRateHz         = st_r.symRate;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence pktStart_s;
		wrEn && st_r.addr == ADDR_OPMODE && rxByte[2:0] == MODE_TX
			&& st_r.mode == MODE_STDBY;
	endsequence
	sequence inPacket_s;
		(st_r.mode == MODE_TX || st_r.mode == MODE_RX) && !wrEn && !hdrCrValid;
	endsequence

	range_lock_a: assert property (wrEn && st_r.addr == ADDR_OPMODE
		&& st_r.mode != MODE_SLEEP |=> $stable(longRangeSel))
		else $error("range select changed outside Sleep");
	map_swap_a: assert property (st_r.longRange == 1'b0 && loadAddr != ADDR_OPMODE
		|-> rdMux == 8'h00)
		else $error("modem register visible in the other map");
	fifo_step_a: assert property (fifoAccess |=>
		st_r.fifoPtr == $past(st_r.fifoPtr) + 8'h01)
		else $error("FIFO pointer did not advance");
	sf_chips_a: assert property (st_r.sf >= SF_MIN && st_r.sf <= SF_MAX
		&& chipsPerSymbol == (13'h0001 << activeSpread))
		else $error("spread exponent or chip count wrong");
	cr_overhead_a: assert property (activeCodeRatio >= CR_MIN
		&& activeCodeRatio <= CR_MAX && codeOverheadQuarters == activeCodeRatio + 3'h4)
		else $error("code ratio overhead wrong");
	hdr_adopt_a: assert property (hdrCrValid && !st_r.actHdrless && hdrCr == 3'h3
		|=> activeCodeRatio == 3'h3 && codeOverheadQuarters == 4'h7)
		else $error("header code ratio not adopted");
	sym_rate_a: assert property (activeBandwidth <= BW_MAX
		&& symbolRateHz == (sms_bw_hz(activeBandwidth) >> activeSpread))
		else $error("symbol rate mismatch");
	hdrless_a: assert property (wrEn && st_r.longRange && st_r.addr == ADDR_SYMTO_HI
		|=> st_r.headerless == $past(rxByte[HDRLESS_BIT]))
		else $error("headerless select not stored");
	pkt_latch_a: assert property (pktStart_s |=> activeSpread == $past(st_r.sf)
		&& activeBandwidth == $past(st_r.bw))
		else $error("parameters not taken at packet start");
	pkt_hold_a: assert property (inPacket_s |=> $stable(activeSpread)
		&& $stable(activeBandwidth) && $stable(activeCodeRatio))
		else $error("parameters changed inside a packet");

endmodule : sms_modem_setup

// file: common/sms_pkg.sv
/*
 * Shared constants for the spread-spectrum modem setup block: register
 * offsets, field positions, reset values, operating-mode codes and the
 * bandwidth table.
 * Assumes a byte-wide SPI register port with a 7-bit address space.
 */
package sms_pkg;

	// Register offsets on the SPI port.
	localparam logic [6:0] ADDR_FIFO         = 7'h00;
	localparam logic [6:0] ADDR_OPMODE       = 7'h01;
	localparam logic [6:0] ADDR_FIFO_PTR     = 7'h0D;
	localparam logic [6:0] ADDR_TX_SETUP     = 7'h1D;
	localparam logic [6:0] ADDR_MODEM_SETUP2 = 7'h1E;
	localparam logic [6:0] ADDR_SYMTO_HI     = 7'h1F;
	localparam logic [6:0] ADDR_ACTIVE       = 7'h20;
	localparam logic [6:0] ADDR_SF6_TUNE     = 7'h31;
	localparam logic [6:0] ADDR_SF6_THR      = 7'h37;

	// Field positions.
	localparam int OPM_RANGE_BIT = 7;
	localparam int HDRLESS_BIT   = 2;
	localparam int SF_LSB        = 4;
	localparam int CR_LSB        = 1;
	localparam int BW_LSB        = 4;

	// Operating-mode codes in the low three bits of the mode register.
	localparam logic [2:0] MODE_SLEEP = 3'h0;
	localparam logic [2:0] MODE_STDBY = 3'h1;
	localparam logic [2:0] MODE_TX    = 3'h3;
	localparam logic [2:0] MODE_RX    = 3'h5;

	// Legal field ranges.
	localparam logic [3:0] SF_MIN = 4'h6;
	localparam logic [3:0] SF_MAX = 4'hC;
	localparam logic [2:0] CR_MIN = 3'h1;
	localparam logic [2:0] CR_MAX = 3'h4;
	localparam logic [3:0] BW_MAX = 4'h9;

	// Values after reset.
	localparam logic [3:0] SF_RST    = 4'h7;
	localparam logic [2:0] CR_RST    = 3'h1;
	localparam logic [3:0] BW_RST    = 4'h7;
	localparam logic [7:0] TUNE_RST  = 8'h00;
	localparam logic [7:0] THR_RST   = 8'h00;
	localparam logic [7:0] PTR_RST   = 8'h00;
	localparam logic [12:0] CHIPS_RST = 13'h0080;
	localparam logic [3:0]  OVH_RST   = 4'h5;
	localparam logic [18:0] RATE_RST  = 19'h0_03D0;

	// Total (double sideband) bandwidth in Hz for each bandwidth code.
	function automatic logic [18:0] sms_bw_hz(input logic [3:0] code);
		unique case (code)
			4'h0:    sms_bw_hz = 19'h0_1E78;
			4'h1:    sms_bw_hz = 19'h0_28A0;
			4'h2:    sms_bw_hz = 19'h0_3CF0;
			4'h3:    sms_bw_hz = 19'h0_5140;
			4'h4:    sms_bw_hz = 19'h0_79E0;
			4'h5:    sms_bw_hz = 19'h0_A2E4;
			4'h6:    sms_bw_hz = 19'h0_F424;
			4'h7:    sms_bw_hz = 19'h1_E848;
			4'h8:    sms_bw_hz = 19'h3_D090;
			default: sms_bw_hz = 19'h7_A120;
		endcase
	endfunction : sms_bw_hz

endpackage : sms_pkg

// file: design/sms_dual_buffer.sv
/*
 * Dual-port byte buffer shared by the SPI port (port A, read without
 * latency) and the modem datapath (port B, registered read).
 * Assumes both ports run on the one block clock.
 */
`timescale 1ns/1ns
module sms_dual_buffer #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic [AW-1:0] aAddr,
	input  wire logic          aWe,
	input  wire logic [DW-1:0] aWdata,
	output logic      [DW-1:0] aRdata,
	input  wire logic [AW-1:0] bAddr,
	input  wire logic          bWe,
	input  wire logic [DW-1:0] bWdata,
	output logic      [DW-1:0] bRdata
);

	logic [DW-1:0] mem [2**AW];

	assign aRdata = mem[aAddr];

	// On a write collision to one address the SPI side wins, so the host
	// always sees what it last wrote.
	always_ff @(posedge clk) begin
		if (bWe && !(aWe && aAddr == bAddr)) begin
			mem[bAddr] <= bWdata;
		end
		if (aWe) begin
			mem[aAddr] <= aWdata;
		end
		bRdata <= mem[bAddr];
	end

endmodule : sms_dual_buffer

// file: test/sms_host_model.sv
/*
 * Host microcontroller model: an SPI mode 0 master that runs one
 * two-byte access per frame.
 * Assumes the bench calls its task by hierarchical name.
 */
`timescale 1ns/1ns
module sms_host_model (
	input  wire logic refClk,
	output logic      sck,
	output logic      nss_n,
	output logic      mosi,
	input  wire logic miso
);
	// Six block cycles per half period keeps sck below the sync limit.
	localparam int HALF = 6;

	initial {sck, nss_n, mosi} = 3'b010;

	task automatic access(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] sh;
		sh = {cmd, wd};
		@(negedge refClk) nss_n = 1'b0;
		repeat (HALF) @(negedge refClk);
		for (int i = 15; i >= 0; i--) begin
			mosi = sh[i];
			repeat (HALF) @(negedge refClk);
			sck = 1'b1;
			rd = {rd[6:0], miso};
			repeat (HALF) @(negedge refClk);
			sck = 1'b0;
		end
		repeat (HALF) @(negedge refClk);
		nss_n = 1'b1;
		// A released data line must not keep showing the last bit.
		mosi = ~mosi;
		repeat (HALF) @(negedge refClk);
	endtask : access

endmodule : sms_host_model

// file: test/testbench.sv
/*
 * Self-checking bench for the modem setup block: mode select, map swap,
 * parameter decode and latching, header code ratio and the FIFO.
 * Assumes the host model drives the SPI pins.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errTotal++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench
	import sms_pkg::*;
;
	logic        refClk, rst, sck, nss_n, mosi, miso, misoOe, hdrCrValid, fWe, lrSel, aHlO;
	logic [2:0]  hdrCr, opMode, aCrO;
	logic [7:0]  fAddr, fWd, fRd, r8;
	logic [3:0]  aSfO, aBwO, ovh;
	logic [12:0] chips;
	logic [18:0] symRate;
	logic [31:0] seed;
	logic [3:0]  sf, bw, eSf, eBw, aSf, aBw;
	logic [2:0]  cr, eCr, aCr, hc;
	logic        hl, eHl, aHl;
	int          errTotal, compares, cycles;
	localparam logic [18:0] BWT [10] = '{19'h0_1E78, 19'h0_28A0, 19'h0_3CF0, 19'h0_5140,
		19'h0_79E0, 19'h0_A2E4, 19'h0_F424, 19'h1_E848, 19'h3_D090, 19'h7_A120};

	sms_host_model host (.refClk(refClk), .sck(sck), .nss_n(nss_n), .mosi(mosi), .miso(miso));
	sms_modem_setup dut (.ref_clk(refClk), .rst(rst), .spiSck(sck), .spiNss_n(nss_n),
		.spiMosi(mosi), .spiMiso(miso), .spiMisoOe(misoOe), .hdrCrValid(hdrCrValid),
		.hdrCr(hdrCr), .modemFifoAddr(fAddr), .modemFifoWe(fWe), .modemFifoWdata(fWd),
		.modemFifoRdata(fRd), .longRangeSel(lrSel), .opMode(opMode), .activeSpread(aSfO),
		.activeCodeRatio(aCrO), .activeBandwidth(aBwO), .activeHeaderless(aHlO),
		.chipsPerSymbol(chips), .codeOverheadQuarters(ovh), .symbolRateHz(symRate));

	initial refClk = 1'b0;
	always #10 refClk = ~refClk;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		host.access({1'b1, a}, d, r);
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		host.access({1'b0, a}, 8'h00, d);
	endtask : rd

	task automatic checkActive;
		`CHK("spread", aSf, aSfO)
		`CHK("ratio", aCr, aCrO)
		`CHK("bandwidth", aBw, aBwO)
		`CHK("headerless", aHl, aHlO)
		`CHK("chips", 13'h0001 << aSf, chips)
		`CHK("overhead", 4'h4 + {1'b0, aCr}, ovh)
		`CHK("symrate", BWT[aBw] >> aSf, symRate)
	endtask : checkActive

	task automatic printVerdict;
		$display("compares %0d mismatches %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : printVerdict

	always @(posedge refClk) begin
		cycles++;
		if (cycles == 80000) begin
			errTotal++;
			printVerdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		hdrCrValid = 1'b0;
		hdrCr = 3'h0;
		fAddr = 8'h00;
		fWe = 1'b0;
		fWd = 8'h00;
		seed = 32'h0000_a9a4;
		{aSf, aCr, aBw, aHl} = {SF_RST, CR_RST, BW_RST, 1'b0};
		{eSf, eCr, eBw, eHl} = {SF_RST, CR_RST, BW_RST, 1'b0};
		repeat (3) @(posedge refClk);
		@(negedge refClk) rst = 1'b0;
		repeat (4) @(negedge refClk);
		checkActive();
		`CHK("oe", 1'b0, misoOe)
		rd(ADDR_MODEM_SETUP2, r8);
		`CHK("fskmap", 8'h00, r8)
		wr(ADDR_OPMODE, 8'h01);
		wr(ADDR_OPMODE, 8'h81);
		`CHK("lrsel", 1'b0, lrSel)
		wr(ADDR_OPMODE, 8'h00);
		wr(ADDR_OPMODE, 8'h80);
		`CHK("lrsel", 1'b1, lrSel)
		rd(ADDR_MODEM_SETUP2, r8);
		`CHK("lrmap", 8'h70, r8 & 8'hF0)
		rd(7'h7F, r8);
		`CHK("unmapped", 8'h00, r8)
		rd(ADDR_SF6_THR, r8);
		`CHK("thrRst", THR_RST, r8)
		wr(ADDR_FIFO_PTR, 8'h10);
		wr(ADDR_FIFO, 8'h5A);
		wr(ADDR_FIFO, 8'hC3);
		rd(ADDR_FIFO_PTR, r8);
		`CHK("fifoPtr", 8'h12, r8)
		@(negedge refClk) fAddr = 8'h11;
		@(negedge refClk) `CHK("fifoB", 8'hC3, fRd)
		seed = xs(seed);
		fAddr = 8'h40;
		fWd = seed[7:0];
		fWe = 1'b1;
		@(negedge refClk) fWe = 1'b0;
		wr(ADDR_FIFO_PTR, 8'h40);
		rd(ADDR_FIFO, r8);
		`CHK("fifoA", seed[7:0], r8)
		for (int i = 0; i < 18; i++) begin
			wr(ADDR_OPMODE, 8'h81);
			seed = xs(seed);
			{hl, bw, cr, sf} = seed[11:0];
			if (i == 0) {sf, cr, bw, hl} = {4'h6, 3'h4, 4'h0, 1'b1};
			if (i == 1) {sf, cr, bw, hl} = {4'hC, 3'h1, 4'h9, 1'b0};
			if (i == 2) {sf, cr, bw} = {4'h5, 3'h0, 4'hA};
			if (sf == 4'h6) hl = 1'b1;
			wr(ADDR_MODEM_SETUP2, {sf, 4'h0});
			wr(ADDR_TX_SETUP, {bw, cr, 1'b0});
			wr(ADDR_SYMTO_HI, {5'h00, hl, 2'h0});
			if (sf == 4'h6) begin
				wr(ADDR_SF6_TUNE, 8'h05);
				wr(ADDR_SF6_THR, 8'h0C);
				rd(ADDR_SF6_THR, r8);
				`CHK("thr", 8'h0C, r8)
			end
			if (sf >= SF_MIN && sf <= SF_MAX) eSf = sf;
			if (cr >= CR_MIN && cr <= CR_MAX) eCr = cr;
			if (bw <= BW_MAX) eBw = bw;
			eHl = hl;
			checkActive();
			wr(ADDR_OPMODE, i[0] ? {5'h10, MODE_RX} : {5'h10, MODE_TX});
			`CHK("mode", i[0] ? MODE_RX : MODE_TX, opMode)
			{aSf, aCr, aBw, aHl} = {eSf, eCr, eBw, eHl};
			checkActive();
			rd(ADDR_ACTIVE, r8);
			`CHK("status", {aSf, aCr, aHl}, r8)
			hc = {1'b0, seed[13:12]} + 3'h1;
			if (i == 1) hc = 3'h3;
			@(negedge refClk) begin
				hdrCrValid = 1'b1;
				hdrCr = hc;
			end
			@(negedge refClk) hdrCrValid = 1'b0;
			if (!aHl) aCr = hc;
			@(negedge refClk) checkActive();
		end
		printVerdict();
	end

endmodule : testbench
